/* bench/fwsrg_chk.sv */
// Port assertions for the writer status and register gate
`timescale 1ns/1ps
module fwsrg_chk (
   input wire clk,
   input wire rst,
   input wire [1:0] mode,
   input wire flash_reg_window_enable,
   input wire [15:0] cpu_addr,
   input wire cpu_rd,
   input wire cpu_wr,
   input wire [7:0] cpu_wdata,
   input wire [7:0] cpu_rdata_r,
   input wire cpu_int_ack_r,
   input wire cpu_ext_r,
   input wire [7:0] flash_control_one_r,
   input wire [7:0] flash_control_two_r,
   input wire [7:0] erase_block_select_two_r,
   input wire cmd_ready_r,
   input wire eng_prog_go_r,
   input wire eng_erase_go_r
);
   // Decoded access of the three gated addresses
   wire en = flash_reg_window_enable;
   wire acc = cpu_rd | cpu_wr;
   wire hit = cpu_addr == 16'hff80 || cpu_addr == 16'hff81
      || cpu_addr == 16'hff83;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_RST: assert property ($fell(rst) |->
      flash_control_one_r == 8'h80 && flash_control_two_r == 8'h00
      && erase_block_select_two_r == 8'h00) else $error("reset values");
   AST_EXT: assert property (acc && hit && !en && mode != 2'h3
      |=> cpu_ext_r && !cpu_int_ack_r) else $error("no external pulse");
   AST_RSV: assert property (cpu_rd && hit
      && (mode == 2'h1 && en || mode == 2'h3 && !en)
      |=> cpu_int_ack_r && cpu_rdata_r == 8'hff) else $error("reserved read");
   AST_KEEP: assert property (cpu_wr && (mode == 2'h1 || !en)
      |=> $stable(flash_control_one_r) && $stable(flash_control_two_r)
      && $stable(erase_block_select_two_r)) else $error("closed write");
   AST_WR: assert property (cpu_wr && en && mode == 2'h2
      && cpu_addr == 16'hff81 |=> flash_control_two_r == $past(cpu_wdata))
      else $error("write lost");
   AST_RD: assert property (cpu_rd && en && mode == 2'h3
      && cpu_addr == 16'hff80 |=> cpu_int_ack_r
      && cpu_rdata_r == flash_control_one_r) else $error("read wrong");
   AST_MISS: assert property (acc && !hit
      |=> !cpu_int_ack_r && !cpu_ext_r) else $error("stray answer");
   AST_LOCK: assert property (!cmd_ready_r
      |-> !eng_prog_go_r && !eng_erase_go_r) else $error("early start");
   AST_RDY: assert property (cmd_ready_r |=> cmd_ready_r)
      else $error("ready dropped");
endmodule
bind fwsrg_top fwsrg_chk chk_u (.clk, .rst, .mode,
   .flash_reg_window_enable, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata,
   .cpu_rdata_r, .cpu_int_ack_r, .cpu_ext_r, .flash_control_one_r,
   .flash_control_two_r, .erase_block_select_two_r, .cmd_ready_r,
   .eng_prog_go_r, .eng_erase_go_r);

/* bench/fwsrg_eng_model.sv */
// Program and erase engine with a patterned array behind the sequencer
`timescale 1ns/1ps
module fwsrg_eng_model (
   input wire clk,
   input wire rst,
   input wire [16:0] arr_addr_r,
   output wire [7:0] arr_rdata,
   input wire eng_prog_go_r,
   input wire eng_erase_go_r,
   input wire [7:0] dly,
   input wire [3:0] res,
   output reg eng_done,
   output wire eng_ok,
   output wire eng_perr,
   output wire eng_eerr,
   output wire eng_cnt_exc
);
   reg [7:0] cnt_r;
   reg busy_r;
   // Pattern array; all ones only where the low address byte is a5, so the blank reads tested come from the block
   assign arr_rdata = arr_addr_r[7:0] ^ 8'h5a;
   // Result flags are only valid with done, inverted otherwise
   assign {eng_ok, eng_perr, eng_eerr, eng_cnt_exc} = eng_done ? res : ~res;
   // Busy countdown of dly+1 cycles after a start pulse
   always @(posedge clk) begin
      eng_done <= 1'b0;
      if (rst) begin
         busy_r <= 1'b0;
      end else if (eng_prog_go_r | eng_erase_go_r) begin
         busy_r <= 1'b1;
         cnt_r <= dly;
      end else if (busy_r) begin
         cnt_r <= cnt_r - 8'h01;
         if (cnt_r == 8'h00) begin
            busy_r <= 1'b0;
            eng_done <= 1'b1;
         end
      end
   end
endmodule

/* bench/test_flash_writer_status_and_reg_gate.sv */
// Self-checking bench for the writer status and register gate
`timescale 1ns/1ps
module test_flash_writer_status_and_reg_gate;
   reg clk = 0, rst = 1, wr_ce_n = 1, wr_oe_n = 1, wr_we_n = 1;
   reg [16:0] wr_addr = 0;
   reg [7:0] wr_din = 0, cpu_wdata = 0, dly = 8'h3c;
   reg [1:0] mode = 2'h3;
   reg flash_reg_window_enable = 1, cpu_rd = 0, cpu_wr = 0, wsmp = 0;
   reg [15:0] cpu_addr = 0;
   reg [3:0] res = 4'h8;
   wire [7:0] wr_dout_r, arr_rdata, cpu_rdata_r, flash_control_one_r;
   wire [7:0] flash_control_two_r, erase_block_select_two_r;
   wire wr_doe_r, cmd_ready_r, eng_prog_go_r, eng_erase_go_r, eng_done;
   wire eng_ok, eng_perr, eng_eerr, eng_cnt_exc, cpu_int_ack_r, cpu_ext_r;
   wire [16:0] arr_addr_r, eng_addr_r;
   wire pg_we_r;
   wire [6:0] pg_idx_r;
   wire [7:0] pg_data_r;
   reg [14:0] pq[$];
   reg [16:0] aq[$];
   reg [7:0] d8;
   integer seed = 32'h1c487c45, fail_count = 0, n_tests = 0, i, k;
   reg [10:0] cq[$];
   reg [8:0] wq[$];
   reg [10:0] e;
   reg [7:0] m [0:3];
   initial forever #5 clk = ~clk;
   fwsrg_top #(.OSC_CYC(20'd20), .SETUP_CYC(20'd20)) dut_u (.clk, .rst,
      .wr_ce_n, .wr_oe_n, .wr_we_n, .wr_addr, .wr_din, .wr_dout_r,
      .wr_doe_r, .cmd_ready_r, .arr_addr_r, .arr_rdata, .pg_we_r,
      .pg_idx_r, .pg_data_r, .eng_prog_go_r, .eng_erase_go_r,
      .eng_addr_r, .eng_done, .eng_ok, .eng_perr, .eng_eerr, .eng_cnt_exc,
      .mode, .flash_reg_window_enable, .cpu_addr, .cpu_rd, .cpu_wr,
      .cpu_wdata, .cpu_rdata_r, .cpu_int_ack_r, .cpu_ext_r,
      .flash_control_one_r, .flash_control_two_r, .erase_block_select_two_r);
   fwsrg_eng_model eng_u (.clk, .rst, .arr_addr_r, .arr_rdata,
      .eng_prog_go_r, .eng_erase_go_r, .dly, .res, .eng_done, .eng_ok,
      .eng_perr, .eng_eerr, .eng_cnt_exc);
   task wrap_up;
      begin
         // Notes left without a matching result add one mismatch in total
         if (cq.size() || wq.size() || pq.size() || aq.size()) fail_count++;
         $display("comparisons %0d mismatches %0d", n_tests, fail_count);
         if (fail_count == 0 && n_tests > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   task chk_cpu(input [9:0] x, input [9:0] g);
      begin
         n_tests++;
         if (x !== g) begin
            fail_count++;
            $display("CHECK FAILED cpu answer exp %h got %h", x, g);
         end
      end
   endtask
   task chk_wr(input [8:0] x, input [8:0] g);
      begin
         n_tests++;
         if (x !== g) begin
            fail_count++;
            $display("CHECK FAILED writer output exp %h got %h", x, g);
         end
      end
   endtask
   task chk_pg(input [14:0] x, input [14:0] g);
      begin
         n_tests++;
         if (x !== g) begin
            fail_count++;
            $display("CHECK FAILED page byte exp %h got %h", x, g);
         end
      end
   endtask
   task chk_addr(input [16:0] x, input [16:0] g);
      begin
         n_tests++;
         if (x !== g) begin
            fail_count++;
            $display("CHECK FAILED page base exp %h got %h", x, g);
         end
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk);
   endtask
   // CPU access; notes the expected answer kind and data
   task cpu(input w, input [15:0] a, input [7:0] d);
      reg [1:0] kd;
      reg rsv;
      begin
         kd = a[1:0] == 2'h2 ? 2'h0 : !flash_reg_window_enable
            && mode != 2'h3 ? 2'h2 : 2'h1;
         rsv = mode == 2'h1 && flash_reg_window_enable
            || mode == 2'h3 && !flash_reg_window_enable;
         // Reserved and external reads leave all ones in the read data
         if (kd != 0) cq.push_back({!w, kd,
            rsv || kd == 2'h2 ? 8'hff : m[a[1:0]]});
         if (w && kd == 1 && !rsv) m[a[1:0]] = d;
         @(posedge clk);
         cpu_rd <= !w;
         cpu_wr <= w;
         cpu_addr <= a;
         cpu_wdata <= d;
         @(posedge clk);
         cpu_rd <= 0;
         cpu_wr <= 0;
      end
   endtask
   // Writer command stroke, data held past the rising write strobe
   task wcmd(input [16:0] a, input [7:0] d);
      begin
         @(posedge clk);
         wr_ce_n <= 0;
         wr_addr <= a;
         wr_din <= d;
         wr_we_n <= 0;
         tick(2);
         wr_we_n <= 1;
         tick(4);
      end
   endtask
   task wread(input [16:0] a, input [7:0] x);
      begin
         @(posedge clk);
         wr_addr <= a;
         wr_oe_n <= 0;
         tick(7);
         wq.push_back({1'b1, x});
         wsmp <= 1;
         @(posedge clk);
         wsmp <= 0;
         wr_oe_n <= 1;
      end
   endtask
   task prog(input [16:0] a);
      begin
         aq.push_back({a[16:7], 7'h00});
         wcmd(a, 8'h40);
         for (i = 0; i < 128; i++) begin
            d8 = $random(seed);
            pq.push_back({i[6:0], d8});
            wcmd(a + i, d8);
         end
      end
   endtask
   task wdone;
      begin
         k = 0;
         while (eng_done !== 1'b1 && k < 1000) begin
            @(posedge clk);
            k++;
         end
         if (k == 1000) begin
            fail_count++;
            wrap_up;
         end else begin
            tick(8);
         end
      end
   endtask
   // Answer watchers take the oldest note per result
   always @(posedge clk) if (cpu_int_ack_r | cpu_ext_r) begin
      e = cq.size() ? cq.pop_front() : 11'h000;
      chk_cpu({e[10] ? e[7:0] : cpu_rdata_r, e[9:8]},
         {cpu_rdata_r, cpu_ext_r, cpu_int_ack_r});
   end
   always @(posedge clk) if (wsmp) chk_wr(wq.pop_front(),
      {wr_doe_r, wr_dout_r});
   always @(posedge clk) if (pg_we_r) chk_pg(pq.pop_front(),
      {pg_idx_r, pg_data_r});
   always @(posedge clk) if (eng_prog_go_r) chk_addr(aq.pop_front(),
      eng_addr_r);
   initial begin
      m[0] = 8'h80;
      m[1] = 8'h00;
      m[2] = 8'h00;
      m[3] = 8'h00;
      tick(12);
      rst <= 0;
      wcmd(17'h0, 8'h20);
      cpu(0, 16'hff80, 0);
      cpu(0, 16'hff81, 0);
      cpu(0, 16'hff83, 0);
      cpu(0, 16'hff82, 0);
      // Each mode and window setting, write then read back
      for (i = 0; i < 6; i++) begin
         @(posedge clk);
         mode <= i / 2 + 1;
         flash_reg_window_enable <= i[0];
         @(posedge clk);
         for (k = 0; k < 4; k++) if (k != 2) begin
            cpu(1, {14'h3fe0, k[1:0]}, $random(seed));
            cpu(0, {14'h3fe0, k[1:0]}, 0);
         end
      end
      // Leave no program or erase bit set after the random writes
      cpu(1, 16'hff80, 8'h80);
      cpu(0, 16'hff80, 0);
      k = 0;
      while (cmd_ready_r !== 1'b1 && k < 200) begin
         @(posedge clk);
         k++;
      end
      if (k == 200) begin
         fail_count++;
         wrap_up;
      end
      wread(17'h00123, 8'h79);
      wread(17'h0f780, 8'hff);
      wread(17'h1ffff, 8'hff);
      wcmd(0, 8'h20);
      wread(0, 8'h00);
      wdone;
      wread(0, 8'hc0);
      wread(17'h00555, 8'hc0);
      prog(17'h00310);
      wread(0, 8'h00);
      wdone;
      wread(0, 8'h80);
      wcmd(0, 8'h71);
      wread(0, 8'h81);
      wcmd(0, 8'h71);
      wread(0, 8'h81);
      res <= 4'h3;
      wcmd(0, 8'h20);
      wdone;
      wcmd(0, 8'h71);
      wread(0, 8'h92);
      res <= 4'h4;
      dly <= 8'h02;
      prog(17'h00400);
      wdone;
      wread(0, 8'h80);
      wcmd(0, 8'h71);
      wread(0, 8'ha0);
      wcmd(0, 8'h00);
      wcmd(0, 8'h71);
      wread(0, 8'h00);
      wcmd(0, 8'h55);
      wread(0, 8'hc0);
      tick(20);
      wrap_up;
   end
endmodule

/* core/fwsrg_cpu_regs.v */
// CPU side flash control registers gated by the window enable
`timescale 1ns/1ps
`include "fwsrg_map.vh"
module fwsrg_cpu_regs (
   input wire clk,
   input wire rst,
   input wire [1:0] mode,
   input wire flash_reg_window_enable,
   input wire [15:0] addr,
   input wire rd,
   input wire wr,
   input wire [7:0] wdata,
   output reg [7:0] rdata_r,
   output reg int_ack_r,
   output reg ext_r,
   output reg [7:0] flash_control_one_r,
   output reg [7:0] flash_control_two_r,
   output reg [7:0] erase_block_select_two_r
);
   // Address to register index, zero when no register matches
   function [1:0] fwsrg_sel;
      input [15:0] a;
      begin
         case (a)
            `FWSRG_FC1_ADDR: fwsrg_sel = 2'h1;
            `FWSRG_FC2_ADDR: fwsrg_sel = 2'h2;
            `FWSRG_EBR_ADDR: fwsrg_sel = 2'h3;
            default: fwsrg_sel = 2'h0;
         endcase
      end
   endfunction

   wire [1:0] rsel = fwsrg_sel(addr);
   wire hit = rsel != 2'h0;
   wire m1 = mode == `FWSRG_MODE1;
   wire m3 = mode == `FWSRG_MODE3;
   // Registers live only with the window open, in every mode but mode 1
   wire live = flash_reg_window_enable & ~m1;
   // Mode 1 open and mode 3 closed give all-ones reserved area
   wire rsvd = m1 ? flash_reg_window_enable
                  : (m3 & ~flash_reg_window_enable);
   reg [7:0] reg_val;

   // Read value of the selected register
   always @* begin
      case (rsel)
         2'h1: reg_val = flash_control_one_r;
         2'h2: reg_val = flash_control_two_r;
         2'h3: reg_val = erase_block_select_two_r;
         default: reg_val = `FWSRG_RSVD;
      endcase
   end

   // Register writes, reserved area ignores writes
   always @(posedge clk) begin
      if (rst) begin
         flash_control_one_r <= `FWSRG_FC1_RST;
         flash_control_two_r <= `FWSRG_FC2_RST;
         erase_block_select_two_r <= `FWSRG_EBR_RST;
      end else if (wr && live) begin
         case (fwsrg_sel(addr))
            2'h1: flash_control_one_r <= wdata;
            2'h2: flash_control_two_r <= wdata;
            2'h3: erase_block_select_two_r <= wdata;
            default: ;
         endcase
      end
   end

   // Answer: internal data, all ones, or hand to external space
   always @(posedge clk) begin
      if (rst) begin
         rdata_r <= 8'h00;
         int_ack_r <= 1'b0;
         ext_r <= 1'b0;
      end else begin
         int_ack_r <= hit & (rd | wr) & (live | rsvd);
         ext_r <= hit & (rd | wr) & ~live & ~rsvd;
         if (hit && rd) begin
            rdata_r <= live ? reg_val : `FWSRG_RSVD;
         end
      end
   end
endmodule

/* core/fwsrg_map.vh */
// Constants for the flash writer status and register gate
`ifndef FWSRG_MAP_VH
`define FWSRG_MAP_VH

// Clock rate and settling times
`define FWSRG_CYC_PER_MS 100000
`define FWSRG_OSC_MS 10
`define FWSRG_SETUP_MS 10

// Writer command codes (data byte of a command write)
`define FWSRG_CMD_READ 8'h00
`define FWSRG_CMD_PROG 8'h40
`define FWSRG_CMD_ERASE 8'h20
`define FWSRG_CMD_STAT 8'h71

// Auto-program page
`define FWSRG_PAGE_LAST 7'h7f
`define FWSRG_PAGE_LO0 8'h00
`define FWSRG_PAGE_LO1 8'h80

// Unimplemented array range
`define FWSRG_UNIMP_LO 17'h0f780
`define FWSRG_BLANK 8'hff

// Return code bit positions
`define FWSRG_RC_END 7
`define FWSRG_RC_CMD 6
`define FWSRG_RC_PRG 5
`define FWSRG_RC_ERS 4
`define FWSRG_RC_CNT 1
`define FWSRG_RC_ADR 0
`define FWSRG_RC_RST 8'h00

// CPU side flash control registers
`define FWSRG_FC1_ADDR 16'hff80
`define FWSRG_FC2_ADDR 16'hff81
`define FWSRG_EBR_ADDR 16'hff83
`define FWSRG_FC1_RST 8'h80
`define FWSRG_FC2_RST 8'h00
`define FWSRG_EBR_RST 8'h00
`define FWSRG_RSVD 8'hff

// Operating modes
`define FWSRG_MODE1 2'h1
`define FWSRG_MODE2 2'h2
`define FWSRG_MODE3 2'h3

`endif

/* core/fwsrg_sync.v */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module fwsrg_sync #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   input wire clk,
   input wire rst,
   input wire [W-1:0] d,
   output wire [W-1:0] q
);
   genvar i;

   // One bit chain per input line, each flop driven from one place
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg s1_r;
         reg s2_r;
         always @(posedge clk) begin
            if (rst) begin
               s1_r <= INIT[i];
               s2_r <= INIT[i];
            end else begin
               s1_r <= d[i];
               s2_r <= s1_r;
            end
         end
         assign q[i] = s2_r;
      end
   endgenerate
endmodule

/* core/fwsrg_top.v */
// Writer mode status, polling and command sequencer with CPU register gate
`timescale 1ns/1ps
`include "fwsrg_map.vh"
module fwsrg_top #(
   parameter [19:0] OSC_CYC = `FWSRG_OSC_MS * `FWSRG_CYC_PER_MS,
   parameter [19:0] SETUP_CYC = `FWSRG_SETUP_MS * `FWSRG_CYC_PER_MS
) (
   input wire clk,
   input wire rst,
   input wire wr_ce_n,
   input wire wr_oe_n,
   input wire wr_we_n,
   input wire [16:0] wr_addr,
   input wire [7:0] wr_din,
   output reg [7:0] wr_dout_r,
   output reg wr_doe_r,
   output reg cmd_ready_r,
   output reg [16:0] arr_addr_r,
   input wire [7:0] arr_rdata,
   output reg pg_we_r,
   output reg [6:0] pg_idx_r,
   output reg [7:0] pg_data_r,
   output reg eng_prog_go_r,
   output reg eng_erase_go_r,
   output reg [16:0] eng_addr_r,
   input wire eng_done,
   input wire eng_ok,
   input wire eng_perr,
   input wire eng_eerr,
   input wire eng_cnt_exc,
   input wire [1:0] mode,
   input wire flash_reg_window_enable,
   input wire [15:0] cpu_addr,
   input wire cpu_rd,
   input wire cpu_wr,
   input wire [7:0] cpu_wdata,
   output wire [7:0] cpu_rdata_r,
   output wire cpu_int_ack_r,
   output wire cpu_ext_r,
   output wire [7:0] flash_control_one_r,
   output wire [7:0] flash_control_two_r,
   output wire [7:0] erase_block_select_two_r
);
   // One-hot writer states
   localparam [7:0] S_OSC = 8'h01;
   localparam [7:0] S_SETUP = 8'h02;
   localparam [7:0] S_READ = 8'h04;
   localparam [7:0] S_STAT = 8'h08;
   localparam [7:0] S_LOAD = 8'h10;
   localparam [7:0] S_PROG = 8'h20;
   localparam [7:0] S_ERASE = 8'h40;
   localparam [7:0] S_POLL = 8'h80;

   reg [7:0] state_r;
   reg [7:0] state_nxt;
   reg [19:0] cnt_r;
   reg [19:0] cnt_nxt;
   reg [7:0] rc_r;
   reg [7:0] rc_nxt;
   reg poll_end_r;
   reg poll_end_nxt;
   reg poll_ok_r;
   reg poll_ok_nxt;
   reg first_r;
   reg first_nxt;
   reg [6:0] idx_r;
   reg [6:0] idx_nxt;
   reg we_prev_r;
   reg unimp_r;

   wire ce_n_s;
   wire oe_n_s;
   wire we_n_s;
   wire [16:0] addr_s;
   wire [7:0] din_s;

   // Programmer pins pass two flops before use
   fwsrg_sync #(.W(3), .INIT(3'h7)) u_sync_ctl (
      .clk(clk),
      .rst(rst),
      .d({wr_ce_n, wr_oe_n, wr_we_n}),
      .q({ce_n_s, oe_n_s, we_n_s})
   );

   fwsrg_sync #(.W(25), .INIT(25'h0000000)) u_sync_bus (
      .clk(clk),
      .rst(rst),
      .d({wr_addr, wr_din}),
      .q({addr_s, din_s})
   );

   // Write strobe ends on the rising edge of the enable
   wire wr_stb = ~ce_n_s & we_n_s & ~we_prev_r;
   wire rd_en = ~ce_n_s & ~oe_n_s;
   wire page_ok = (addr_s[7:0] == `FWSRG_PAGE_LO0) |
                  (addr_s[7:0] == `FWSRG_PAGE_LO1);

   // Return code as seen by a status read
   wire [7:0] rc_view = {rc_r[7:4], 2'h0, rc_r[1:0]};

   // Next-state, timer and return code logic
   always @* begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      rc_nxt = rc_r;
      poll_end_nxt = poll_end_r;
      poll_ok_nxt = poll_ok_r;
      first_nxt = first_r;
      idx_nxt = idx_r;
      case (state_r)
         S_OSC: begin
            // Writes are ignored while settling
            if (cnt_r == 20'h00000) begin
               state_nxt = S_SETUP;
               cnt_nxt = SETUP_CYC - 20'h00001;
            end else begin
               cnt_nxt = cnt_r - 20'h00001;
            end
         end
         S_SETUP: begin
            if (cnt_r == 20'h00000) begin
               state_nxt = S_READ;
            end else begin
               cnt_nxt = cnt_r - 20'h00001;
            end
         end
         S_READ, S_STAT, S_POLL: begin
            if (wr_stb) begin
               if (din_s != `FWSRG_CMD_STAT) begin
                  rc_nxt = `FWSRG_RC_RST;
                  poll_end_nxt = 1'b0;
                  poll_ok_nxt = 1'b0;
               end
               case (din_s)
                  `FWSRG_CMD_READ: state_nxt = S_READ;
                  `FWSRG_CMD_STAT: state_nxt = S_STAT;
                  `FWSRG_CMD_PROG: begin
                     state_nxt = S_LOAD;
                     first_nxt = 1'b1;
                     idx_nxt = 7'h00;
                  end
                  `FWSRG_CMD_ERASE: state_nxt = S_ERASE;
                  default: begin
                     // Unknown command: abnormal end, command error
                     state_nxt = S_STAT;
                     rc_nxt[`FWSRG_RC_CMD] = 1'b1;
                     rc_nxt[`FWSRG_RC_END] = 1'b1;
                  end
               endcase
            end
         end
         S_LOAD: begin
            if (wr_stb) begin
               if (first_r) begin
                  first_nxt = 1'b0;
                  if (!page_ok) begin
                     rc_nxt[`FWSRG_RC_ADR] = 1'b1;
                  end
               end
               idx_nxt = idx_r + 7'h01;
               if (idx_r == `FWSRG_PAGE_LAST) begin
                  state_nxt = S_PROG;
               end
            end
         end
         S_PROG, S_ERASE: begin
            // Command writes are not accepted while operating
            if (eng_done) begin
               state_nxt = S_POLL;
               poll_end_nxt = 1'b1;
               poll_ok_nxt = eng_ok & ~rc_r[`FWSRG_RC_ADR];
               rc_nxt[`FWSRG_RC_END] = ~eng_ok | rc_r[`FWSRG_RC_ADR];
               rc_nxt[`FWSRG_RC_PRG] = eng_perr;
               rc_nxt[`FWSRG_RC_ERS] = eng_eerr;
               rc_nxt[`FWSRG_RC_CNT] = eng_cnt_exc;
            end
         end
         default: begin
            state_nxt = S_OSC;
            cnt_nxt = OSC_CYC - 20'h00001;
         end
      endcase
   end

   // State registers
   always @(posedge clk) begin
      if (rst) begin
         state_r <= S_OSC;
         cnt_r <= OSC_CYC - 20'h00001;
         rc_r <= `FWSRG_RC_RST;
         poll_end_r <= 1'b0;
         poll_ok_r <= 1'b0;
         first_r <= 1'b0;
         idx_r <= 7'h00;
         we_prev_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         rc_r <= rc_nxt;
         poll_end_r <= poll_end_nxt;
         poll_ok_r <= poll_ok_nxt;
         first_r <= first_nxt;
         idx_r <= idx_nxt;
         we_prev_r <= we_n_s;
      end
   end

   // Page buffer writes and engine start pulses
   always @(posedge clk) begin
      if (rst) begin
         pg_we_r <= 1'b0;
         pg_idx_r <= 7'h00;
         pg_data_r <= 8'h00;
         eng_prog_go_r <= 1'b0;
         eng_erase_go_r <= 1'b0;
         eng_addr_r <= 17'h00000;
      end else begin
         pg_we_r <= (state_r == S_LOAD) & wr_stb;
         pg_idx_r <= idx_r;
         pg_data_r <= din_s;
         if ((state_r == S_LOAD) && wr_stb && first_r) begin
            // Page address is taken from the first data cycle
            eng_addr_r <= {addr_s[16:7], 7'h00};
         end
         eng_prog_go_r <= (state_r == S_LOAD) & (state_nxt == S_PROG);
         eng_erase_go_r <= (state_r != S_ERASE) &
                           (state_nxt == S_ERASE);
      end
   end

   // Array address and unimplemented range flag
   always @(posedge clk) begin
      if (rst) begin
         arr_addr_r <= 17'h00000;
         unimp_r <= 1'b0;
      end else begin
         arr_addr_r <= addr_s;
         unimp_r <= addr_s >= `FWSRG_UNIMP_LO;
      end
   end

   // Data pins: array, return code or polling flags
   always @(posedge clk) begin
      if (rst) begin
         wr_dout_r <= 8'h00;
         wr_doe_r <= 1'b0;
         cmd_ready_r <= 1'b0;
      end else begin
         wr_doe_r <= rd_en;
         cmd_ready_r <= ~(state_r[0] | state_r[1]);
         case (state_r)
            S_READ: wr_dout_r <= unimp_r ? `FWSRG_BLANK
                                         : arr_rdata;
            S_STAT: wr_dout_r <= rc_view;
            S_PROG, S_ERASE: wr_dout_r <= 8'h00;
            S_POLL: begin
               wr_dout_r <= {poll_end_r, poll_ok_r,
                             6'h00};
            end
            default: wr_dout_r <= 8'h00;
         endcase
      end
   end

   // CPU side register window
   fwsrg_cpu_regs u_cpu_regs (
      .clk(clk),
      .rst(rst),
      .mode(mode),
      .flash_reg_window_enable(flash_reg_window_enable),
      .addr(cpu_addr),
      .rd(cpu_rd),
      .wr(cpu_wr),
      .wdata(cpu_wdata),
      .rdata_r(cpu_rdata_r),
      .int_ack_r(cpu_int_ack_r),
      .ext_r(cpu_ext_r),
      .flash_control_one_r(flash_control_one_r),
      .flash_control_two_r(flash_control_two_r),
      .erase_block_select_two_r(erase_block_select_two_r)
   );
endmodule
